// file: hw/port_move_consts.vh
// constants for the port data move instruction block
`ifndef PORT_MOVE_CONSTS_VH
`define PORT_MOVE_CONSTS_VH

// wishbone byte addresses, one aligned word each
`define ADDR_INSTR 8'h00
`define ADDR_CORE_STATE 8'h04
`define ADDR_PORT_STATE 8'h08
`define ADDR_PIN_STATE 8'h0C
`define ADDR_RAM_INDEX 8'h10
`define ADDR_RAM_DATA 8'h14

// opcode prefixes, address field in opcode[6:0] for reads, writes and stores; wake and direction take opcode[3:0]
`define OP_READ_B 9'h0B7
`define OP_READ_C 9'h096
`define OP_READ_D 9'h097
`define OP_WRITE_A 9'h0B4
`define OP_WRITE_B 9'h0B5
`define OP_WRITE_E 9'h0B8
`define OP_STORE_WR 5'h1E
`define OP_STORE_IMM 5'h17
`define OP_WAKE_EN 12'h521
`define OP_DIR_A 12'h570
`define OP_DIR_B 12'h578

// instruction classes out of the decoder
`define CLS_NONE 4'h0
`define CLS_READ_B 4'h1
`define CLS_READ_C 4'h2
`define CLS_READ_D 4'h3
`define CLS_STORE_WR 4'h4
`define CLS_STORE_IMM 4'h5
`define CLS_WRITE_A 4'h6
`define CLS_WRITE_B 4'h7
`define CLS_WRITE_E 4'h8
`define CLS_WAKE_EN 4'h9
`define CLS_DIR_A 4'hA
`define CLS_DIR_B 4'hB

// reset values
`define DIR_RESET 4'hF
`define LATCH_RESET 4'h0
`define WAKE_RESET 4'h0

// field positions in the core state word
`define ZERO_FLAG_BIT 4
`endif

// file: hw/pin_filter.v
// three-stage pin synchroniser with agreement filter
module pin_filter #(
  parameter WIDTH = 4
) (
  input wire clk,
  input wire rst_b,
  input wire [WIDTH-1:0] pin,
  output reg [WIDTH-1:0] level
);

  reg [WIDTH-1:0] stage1; // metastability catcher, read only by stage2
  reg [WIDTH-1:0] stage2; // first settled copy
  reg [WIDTH-1:0] stage3; // second settled copy

  // shift the pins in; a bit of level moves only when stage2 and stage3 agree
  // so a single-cycle glitch after stage1 never reaches the core
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      level <= {WIDTH{1'b0}};
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= (stage2 & stage3) | (level & (stage2 | stage3));
    end
  end

endmodule

// file: hw/port_data_move_instructions.v
// execution unit for port and ram data move instructions
//
// What this block does
// - port-B read loads ram and accumulator, one cycle
// - port-B read sets zero flag, own prefix
// - port-C read loads ram, accumulator, zero flag
// - port-D read loads ram, accumulator, zero flag
// - working register copied into addressed ram nibble
// - immediate nibble stored into addressed ram nibble
// - port-A latch takes addressed ram nibble
// - port-B latch takes addressed ram nibble
// - port-E latch takes addressed ram nibble
// - per-pin falling edge on port C wakes
// - port-A direction bit zero means output, reset ones
// - port-B direction bit zero means output, reset ones
`include "port_move_consts.vh"

module port_data_move_instructions #(
  parameter RAM_WORDS = 128,
  parameter ADDR_BITS = 7
) (
  input wire clk,
  input wire rst_b,
  // classic wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // bidirectional port a
  input wire [3:0] bidir_port_a_in,
  output reg [3:0] bidir_port_a_out,
  output reg [3:0] bidir_port_a_oe,
  // bidirectional port b
  input wire [3:0] bidir_port_b_in,
  output reg [3:0] bidir_port_b_out,
  output reg [3:0] bidir_port_b_oe,
  // input-only ports
  input wire [3:0] input_port_c,
  input wire [3:0] input_port_d,
  // output-only port e
  output reg [3:0] output_port_e,
  // one-cycle wake request toward the stop-mode controller
  output reg stop_wake
);

  // decode an opcode into its instruction class
  // both five-bit store prefixes have the top bit set and every other prefix
  // has it clear, so no test in this chain can shadow a later one
  function [3:0] decode_class;
    input [15:0] op;
    begin
      if (op[15:7] == `OP_READ_B)
        decode_class = `CLS_READ_B;
      else if (op[15:7] == `OP_READ_C)
        decode_class = `CLS_READ_C;
      else if (op[15:7] == `OP_READ_D)
        decode_class = `CLS_READ_D;
      else if (op[15:7] == `OP_WRITE_A)
        decode_class = `CLS_WRITE_A;
      else if (op[15:7] == `OP_WRITE_B)
        decode_class = `CLS_WRITE_B;
      else if (op[15:7] == `OP_WRITE_E)
        decode_class = `CLS_WRITE_E;
      else if (op[15:11] == `OP_STORE_WR)
        decode_class = `CLS_STORE_WR;
      else if (op[15:11] == `OP_STORE_IMM)
        decode_class = `CLS_STORE_IMM;
      else if (op[15:4] == `OP_WAKE_EN)
        decode_class = `CLS_WAKE_EN;
      else if (op[15:4] == `OP_DIR_A)
        decode_class = `CLS_DIR_A;
      else if (op[15:4] == `OP_DIR_B)
        decode_class = `CLS_DIR_B;
      else
        decode_class = `CLS_NONE;
    end
  endfunction

  // true for the three instructions that load accumulator and ram together
  // shared by the ram write port and the accumulator update
  function is_port_read;
    input [3:0] cls;
    begin
      is_port_read = (cls == `CLS_READ_B) || (cls == `CLS_READ_C) ||
        (cls == `CLS_READ_D);
    end
  endfunction

  // state touched by this group of instructions
  // one ram write port; reads at the opcode address, the working register and the window
  reg [3:0] data_ram [0:RAM_WORDS-1]; // data ram, words 0..15 are working registers
  reg [3:0] accumulator; // accumulator nibble
  reg zero_flag; // set when the last port read loaded zero
  reg [15:0] last_opcode; // opcode most recently issued
  reg [3:0] port_a_direction; // 1 = input, 0 = output
  reg [3:0] port_b_direction; // 1 = input, 0 = output
  reg [3:0] stop_wake_enables; // per pin falling edge wake enables
  reg [ADDR_BITS-1:0] ram_index; // software window pointer into the ram
  reg [3:0] port_c_prev; // filtered port c, one cycle old

  wire [3:0] port_a_level; // filtered pin levels
  wire [3:0] port_b_level;
  wire [3:0] port_c_level;
  wire [3:0] port_d_level;

  // bus decode
  // a request is taken once, on the edge where ack is still low
  wire bus_req; // new request not yet answered
  wire bus_wr; // write accepted this edge
  wire exec; // instruction issued this edge
  wire ram_window_wr; // software write through the ram window

  // instruction fields
  // every field is cut straight out of the low half of the write data
  wire [3:0] op_class;
  wire [ADDR_BITS-1:0] op_addr; // seven-bit ram address field
  wire [3:0] op_wr_sel; // working register select
  wire [3:0] op_imm_store; // immediate for the ram store
  wire [3:0] op_imm_low; // immediate in the low nibble
  wire [3:0] ram_at_addr; // ram nibble addressed by the opcode
  wire [3:0] ram_at_wr; // working register contents

  // combinational feed for the single ram write port
  reg [3:0] port_value; // nibble chosen by a port read
  reg ram_we; // ram write this edge
  reg [ADDR_BITS-1:0] ram_waddr;
  reg [3:0] ram_wdata;
  reg [31:0] next_rdata; // read data to latch with the ack

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i;
  // the opcode only exists as a whole when both low byte lanes are written
  // a narrower write to the instruction address is dropped without effect
  assign exec = bus_wr && (wb_adr_i == `ADDR_INSTR) && wb_sel_i[0] && wb_sel_i[1];
  assign ram_window_wr = bus_wr && (wb_adr_i == `ADDR_RAM_DATA) && wb_sel_i[0];

  assign op_class = decode_class(wb_dat_i[15:0]);
  assign op_addr = wb_dat_i[ADDR_BITS-1:0];
  assign op_wr_sel = wb_dat_i[10:7];
  assign op_imm_store = wb_dat_i[10:7];
  assign op_imm_low = wb_dat_i[3:0];
  assign ram_at_addr = data_ram[op_addr];
  assign ram_at_wr = data_ram[op_wr_sel];

  // pin synchronisers for everything arriving from outside
  // port reads see the filtered level, so a pin change needs four edges
  // before an instruction can load it
  pin_filter #(.WIDTH(4)) sync_a (
    .clk(clk),
    .rst_b(rst_b),
    .pin(bidir_port_a_in),
    .level(port_a_level)
  );

  pin_filter #(.WIDTH(4)) sync_b (
    .clk(clk),
    .rst_b(rst_b),
    .pin(bidir_port_b_in),
    .level(port_b_level)
  );

  pin_filter #(.WIDTH(4)) sync_c (
    .clk(clk),
    .rst_b(rst_b),
    .pin(input_port_c),
    .level(port_c_level)
  );

  pin_filter #(.WIDTH(4)) sync_d (
    .clk(clk),
    .rst_b(rst_b),
    .pin(input_port_d),
    .level(port_d_level)
  );

  // pick the port nibble for the read instructions
  always @* begin
    case (op_class)
      `CLS_READ_B: port_value = port_b_level;
      `CLS_READ_C: port_value = port_c_level;
      `CLS_READ_D: port_value = port_d_level;
      default: port_value = 4'h0; // nothing reads it for other classes
    endcase
  end

  // single ram write port: instruction stores win over the software window
  // since both come from the same bus cycle they can never collide anyway
  always @* begin
    ram_we = 1'b0;
    ram_waddr = op_addr;
    ram_wdata = 4'h0;
    if (exec) begin
      if (is_port_read(op_class)) begin
        ram_we = 1'b1;
        ram_wdata = port_value;
      end else if (op_class == `CLS_STORE_WR) begin
        ram_we = 1'b1;
        ram_wdata = ram_at_wr;
      end else if (op_class == `CLS_STORE_IMM) begin
        ram_we = 1'b1;
        ram_wdata = op_imm_store;
      end
    end else if (ram_window_wr) begin
      // software window: seeds the ram without an instruction
      ram_we = 1'b1;
      ram_waddr = ram_index;
      ram_wdata = wb_dat_i[3:0];
    end
  end

  // ram array itself carries no reset; its contents are software data
  always @(posedge clk) begin
    if (ram_we) begin
      data_ram[ram_waddr] <= ram_wdata;
    end
  end

  // accumulator and zero flag follow every port read
  // the zero flag moves only on the three port reads; stores leave it alone
  // the last opcode is kept for software to read back, whatever its class
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      accumulator <= 4'h0;
      zero_flag <= 1'b0;
      last_opcode <= 16'h0000;
    end else if (exec) begin
      last_opcode <= wb_dat_i[15:0];
      if (is_port_read(op_class)) begin
        accumulator <= port_value;
        zero_flag <= (port_value == 4'h0);
      end
    end
  end

  // port output latches; they hold until the next write to the same port
  // and never track later ram changes
  // a write to one port leaves the other two latches alone
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bidir_port_a_out <= `LATCH_RESET;
      bidir_port_b_out <= `LATCH_RESET;
      output_port_e <= `LATCH_RESET;
    end else if (exec) begin
      case (op_class)
        `CLS_WRITE_A: bidir_port_a_out <= ram_at_addr;
        `CLS_WRITE_B: bidir_port_b_out <= ram_at_addr;
        `CLS_WRITE_E: output_port_e <= ram_at_addr;
        default: bidir_port_a_out <= bidir_port_a_out;
      endcase
    end
  end

  // direction registers and the pin enables they drive
  // oe is kept as the inverse of direction in flops of its own, so the pin
  // enables come straight from registers and never glitch
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port_a_direction <= `DIR_RESET;
      port_b_direction <= `DIR_RESET;
      bidir_port_a_oe <= ~`DIR_RESET;
      bidir_port_b_oe <= ~`DIR_RESET;
    end else if (exec && op_class == `CLS_DIR_A) begin
      port_a_direction <= op_imm_low;
      bidir_port_a_oe <= ~op_imm_low;
    end else if (exec && op_class == `CLS_DIR_B) begin
      port_b_direction <= op_imm_low;
      bidir_port_b_oe <= ~op_imm_low;
    end
  end

  // wake enables and the falling edge detector on filtered port c
  // edges are taken from the filtered level, so a bounce shorter than
  // two cycles does not wake the core
  // the detector resets low like the filter, so the rise of an idle-high
  // pin after reset is never mistaken for a falling edge
  // the enables load on the instruction's edge, so an edge in that very
  // cycle is judged against the old enables
  // limitation: the wake request is one cycle wide; the stop logic must catch it
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_wake_enables <= `WAKE_RESET;
      port_c_prev <= 4'h0;
      stop_wake <= 1'b0;
    end else begin
      port_c_prev <= port_c_level;
      stop_wake <= |(port_c_prev & ~port_c_level & stop_wake_enables);
      if (exec && op_class == `CLS_WAKE_EN) begin
        stop_wake_enables <= op_imm_low;
      end
    end
  end

  // software window pointer
  // only the low seven bits are kept; higher bits of the write are ignored
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ram_index <= {ADDR_BITS{1'b0}};
    end else if (bus_wr && wb_adr_i == `ADDR_RAM_INDEX && wb_sel_i[0]) begin
      ram_index <= wb_dat_i[ADDR_BITS-1:0];
    end
  end

  // read multiplexer; unmapped addresses answer with zero
  // ram data needs the index and the word written first; the ram is not reset
  always @* begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      `ADDR_INSTR: next_rdata = {16'h0000, last_opcode};
      `ADDR_CORE_STATE: begin
        next_rdata[3:0] = accumulator;
        next_rdata[`ZERO_FLAG_BIT] = zero_flag;
      end
      `ADDR_PORT_STATE: next_rdata = {8'h00, stop_wake_enables, port_b_direction,
        port_a_direction, output_port_e, bidir_port_b_out, bidir_port_a_out};
      `ADDR_PIN_STATE: next_rdata = {16'h0000, port_d_level, port_c_level,
        port_b_level, port_a_level};
      `ADDR_RAM_INDEX: next_rdata = {{(32-ADDR_BITS){1'b0}}, ram_index};
      `ADDR_RAM_DATA: next_rdata = {28'h000_0000, data_ram[ram_index]};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // bus answer: ack one cycle after the request, dropped the cycle after
  // trade-off: one wait state on every access buys a fully registered answer
  // read data is latched with ack, so it stands through the ack cycle and
  // holds until the next read is taken
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

endmodule

// file: verification/port_moves_sva.sv
// concurrent checks on the port data move block's pins and bus
module port_moves_checker (
  input wire clk,
  input wire rst_b,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire [3:0] bidir_port_a_out,
  input wire [3:0] bidir_port_a_oe,
  input wire [3:0] bidir_port_b_out,
  input wire [3:0] bidir_port_b_oe,
  input wire [3:0] output_port_e,
  input wire stop_wake
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // an instruction word accepted this edge; other bus traffic leaves ports alone
  wire instr_wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h00 &&
    wb_sel_i[1:0] == 2'b11;
  // set once any wake enable bit was written; until then no wake may appear
  reg en_seen;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_seen <= 1'b0;
    end else if (instr_wr && wb_dat_i[15:4] == 12'h521 && wb_dat_i[3:0] != 4'h0) begin
      en_seen <= 1'b1;
    end
  end
  // a request not yet answered
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // an instruction taken with the given twelve-bit prefix
  sequence s_op(logic [11:0] p);
    instr_wr ##0 wb_dat_i[15:4] == p;
  endsequence
  a_ack_next: assert property (s_take |=> wb_ack_o) else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  a_ack_stray: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  a_dir_a_load: assert property (
    s_op(12'h570) |=> bidir_port_a_oe == ~$past(wb_dat_i[3:0])) else $error("port a oe");
  a_dir_b_load: assert property (
    s_op(12'h578) |=> bidir_port_b_oe == ~$past(wb_dat_i[3:0])) else $error("port b oe");
  a_a_hold: assert property (
    !instr_wr |=> $stable(bidir_port_a_out) && $stable(bidir_port_a_oe)) else $error("a moved");
  a_b_hold: assert property (
    !instr_wr |=> $stable(bidir_port_b_out) && $stable(bidir_port_b_oe)) else $error("b moved");
  a_e_hold: assert property (!instr_wr |=> $stable(output_port_e)) else $error("e moved");
  a_reset_idle: assert property (
    $rose(rst_b) |-> (bidir_port_a_oe | bidir_port_b_oe) == 4'h0) else $error("oe after reset");
  a_wake_gated: assert property (!en_seen |-> !stop_wake) else $error("wake not enabled");
endmodule

// file: verification/port_pins.sv
// far-side devices on the two-way ports: they drive a pin only while the block does not
module port_pins (
  input wire [3:0] a_out,
  input wire [3:0] a_oe,
  input wire [3:0] b_out,
  input wire [3:0] b_oe,
  input wire [3:0] ext_a,
  input wire [3:0] ext_b,
  output wire [3:0] a_pin,
  output wire [3:0] b_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // wire level per pin: the block's drive wins where enabled, the device's elsewhere
  assign a_pin = (a_oe & a_out) | (~a_oe & ext_a);
  assign b_pin = (b_oe & b_out) | (~b_oe & ext_b);
endmodule

// file: verification/test_port_data_move_instructions.sv
// self-checking bench for the port data move block
`include "port_move_consts.vh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module test_port_data_move_instructions;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, ext_a = 4'h0, ext_b = 4'h0, pin_c = 4'hF, pin_d = 4'hF;
  logic [31:0] wdat = 32'h0000_0000;
  wire [31:0] rdat;
  wire ack, wake;
  wire [3:0] a_out, a_oe, b_out, b_oe, a_in, b_in, e_out;
  int errors = 0, n_tests = 0;
  // 125 MHz core clock
  always #4 clk = ~clk;
  port_data_move_instructions dut_u (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .bidir_port_a_in(a_in), .bidir_port_a_out(a_out), .bidir_port_a_oe(a_oe),
    .bidir_port_b_in(b_in), .bidir_port_b_out(b_out), .bidir_port_b_oe(b_oe),
    .input_port_c(pin_c), .input_port_d(pin_d), .output_port_e(e_out), .stop_wake(wake));
  port_pins pins_u (.a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .ext_a(ext_a),
    .ext_b(ext_b), .a_pin(a_in), .b_pin(b_in));
  // verdict and end of run
  task test_done;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one classic cycle; the request is held until ack is sampled, bounded wait
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    q = rdat;
    if (ack !== 1'b1) begin
      errors++;
      test_done;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task exe(input logic [15:0] op);
    logic [31:0] q;
    wb(1'b1, 8'h00, {16'h0000, op}, q);
  endtask
  task chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    `CHK(q & m, e)
  endtask
  task chk_ram(input logic [6:0] a, input logic [3:0] e);
    logic [31:0] q;
    wb(1'b1, 8'h10, {25'h000_0000, a}, q);
    chk_rd(8'h14, 32'h0000_000F, {28'h000_0000, e});
  endtask
  // move port c to p and look for a wake pulse in the next twelve edges
  task wake_try(input logic [3:0] p, input logic e);
    int i;
    logic seen;
    pin_c <= p;
    seen = 1'b0;
    for (i = 0; i < 12; i++) begin
      @(posedge clk);
      if (wake === 1'b1) seen = 1'b1;
    end
    `CHK(seen, e)
  endtask
  initial begin
    logic [31:0] scratch; // answer of a window write, not checked
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    chk_rd(8'h08, 32'h00FF_FFFF, 32'h000F_F000);
    `CHK(a_oe | b_oe, 4'h0)
    chk_rd(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
    exe({`OP_STORE_IMM, 4'hA, 7'h05});
    chk_ram(7'h05, 4'hA);
    exe({`OP_STORE_IMM, 4'h6, 7'h03});
    exe({`OP_STORE_WR, 4'h3, 7'h7F});
    chk_ram(7'h7F, 4'h6);
    exe({`OP_DIR_A, 4'h0});
    `CHK(a_oe, 4'hF)
    exe({`OP_DIR_B, 4'h5});
    `CHK(b_oe, 4'hA)
    exe({`OP_WRITE_A, 7'h7F});
    `CHK(a_out, 4'h6)
    exe({`OP_WRITE_B, 7'h05});
    `CHK(b_out, 4'hA)
    exe({`OP_WRITE_E, 7'h03});
    `CHK(e_out, 4'h6)
    exe({`OP_STORE_IMM, 4'h1, 7'h7F});
    chk_rd(8'h08, 32'h0000_0FFF, 32'h0000_06A6);
    exe({`OP_DIR_B, 4'hF});
    ext_b <= 4'hC;
    pin_c <= 4'h9;
    pin_d <= 4'h0;
    repeat (5) @(posedge clk);
    exe({`OP_READ_B, 7'h10});
    chk_rd(8'h04, 32'h0000_001F, 32'h0000_000C);
    chk_ram(7'h10, 4'hC);
    exe({`OP_READ_C, 7'h11});
    chk_rd(8'h04, 32'h0000_001F, 32'h0000_0009);
    chk_ram(7'h11, 4'h9);
    exe({`OP_READ_D, 7'h12});
    chk_rd(8'h04, 32'h0000_001F, 32'h0000_0010);
    chk_ram(7'h12, 4'h0);
    chk_rd(8'h0C, 32'h0000_FFFF, 32'h0000_09C6);
    chk_rd(8'h00, 32'h0000_FFFF, {16'h0000, `OP_READ_D, 7'h12});
    wb(1'b1, 8'h14, 32'h0000_0003, scratch);
    exe({`OP_WRITE_E, 7'h12});
    `CHK(e_out, 4'h3)
    exe({`OP_WAKE_EN, 4'h2});
    chk_rd(8'h08, 32'h00F0_0000, 32'h0020_0000);
    wake_try(4'hF, 1'b0);
    wake_try(4'hE, 1'b0);
    wake_try(4'hC, 1'b1);
    test_done;
  end
endmodule
bind port_data_move_instructions port_moves_checker chk_u (.clk, .rst_b, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .bidir_port_a_out, .bidir_port_a_oe,
  .bidir_port_b_out, .bidir_port_b_oe, .output_port_e, .stop_wake);
